// file: src/pgd_map.svh
`ifndef PGD_MAP_SVH
`define PGD_MAP_SVH

// register byte offsets on the avalon slave, one aligned word each
`define PGD_OFS_OUTPUT_LATCH   5'h00
`define PGD_OFS_DIRECTION      5'h04
`define PGD_OFS_SLEW_CTRL      5'h08
`define PGD_OFS_DRIVE_SEL      5'h0C
`define PGD_OFS_GANG_CONTROL   5'h10

// field positions inside the gang control register
`define PGD_GANG_ENABLE_BIT    0
`define PGD_GANG_SEL_LSB       1
`define PGD_GANG_SEL_MSB       7

// master pin of the ganged group
`define PGD_MASTER_PIN         0

// reset values
`define PGD_RST_OUTPUT_LATCH   8'h00
`define PGD_RST_DIRECTION      8'h00
`define PGD_RST_SLEW_CTRL      8'h00
`define PGD_RST_DRIVE_SEL      8'h00
`define PGD_RST_GANG_CONTROL   8'h00

// port and bus widths
`define PGD_PORT_W             8
`define PGD_ADDR_W             5
`define PGD_DATA_W             32

`endif

// file: src/pgd_pkg.sv
`default_nettype none
`include "pgd_map.svh"

package pgd_pkg;

  typedef logic [`PGD_PORT_W-1:0] pgd_port_t;
  typedef logic [`PGD_ADDR_W-1:0] pgd_addr_t;
  typedef logic [`PGD_DATA_W-1:0] pgd_data_t;

  // complete state of the port block, registered in one process
  typedef struct packed {
    logic      bus_wait;      // waitrequest level driven on the bus
    pgd_port_t rdata;         // captured read data
    pgd_port_t out_latch;     // port_c_output_latch
    pgd_port_t direction;     // port_c_direction
    pgd_port_t slew_ctrl;     // port_c_slew_ctrl
    pgd_port_t drive_sel;     // port_c_drive_sel
    pgd_port_t gang_ctrl;     // gang_control_reg: selects [7:1], enable [0]
    logic      gang_locked;   // set by the first write to gang_control_reg
    pgd_port_t pin_meta;      // first synchroniser stage
    pgd_port_t pin_sync;      // second synchroniser stage
    pgd_port_t pin_out;
    pgd_port_t pin_oe;
    pgd_port_t pin_slew;
    pgd_port_t pin_drive;
  } pgd_state_t;

endpackage : pgd_pkg

`default_nettype wire

// file: src/pgd_pin_cell.sv
`default_nettype none

// per-pin pad control: picks own settings or the master's while ganged
module pgd_pin_cell #(
  parameter bit IS_MASTER = 1'b0
) (
  // gang steering
  input  wire logic i_use_master,
  input  wire logic i_force_oe,
  // own settings
  input  wire logic i_own_out,
  input  wire logic i_own_dir,
  input  wire logic i_own_slew,
  input  wire logic i_own_drive,
  // master pin settings
  input  wire logic i_mst_out,
  input  wire logic i_mst_slew,
  input  wire logic i_mst_drive,
  // effective pad controls
  output logic      o_out,
  output logic      o_oe,
  output logic      o_slew,
  output logic      o_drive
);

  logic sel;

  // the master never copies itself, so its own settings always win
  assign sel = i_use_master & ~IS_MASTER;

  // an input pin shows no slew or drive request: both are don't-care then
  always_comb begin
    o_out   = sel ? i_mst_out : i_own_out;
    o_oe    = i_own_dir | i_force_oe;
    o_slew  = o_oe & (sel ? i_mst_slew : i_own_slew);
    o_drive = o_oe & (sel ? i_mst_drive : i_own_drive);
  end

endmodule : pgd_pin_cell

`default_nettype wire

// file: src/pgd_top.sv
// Overview of operation
// - Each port pin has a slew-rate enable bit that only matters while the pin drives.
// - Each port pin has a drive-strength bit choosing low or high drive, ignored for inputs.
// - Seven gang select bits [7:1] accept only the first write after reset and add pins to the gang.
// - While ganging is on, each selected pin copies level, drive and slew of master pin 0.
// - A gang select bit acts only when the gang enable is 1, else the pin behaves normally.
// - The gang enable is bit 0 of the gang control register and is write-once after reset.
// - With ganging on, pin 0 drives as an output whatever its direction bit says.
// - Direction 1 enables the driver and data reads give the latch; 0 reads the pin level (here a pin forced to drive by the gang reads the latch).
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`default_nettype none
`include "pgd_map.svh"

module pgd_top (
  // clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_resetn,
  // avalon-mm slave
  input  wire pgd_pkg::pgd_addr_t i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire pgd_pkg::pgd_data_t i_avs_writedata,
  input  wire logic [3:0]         i_avs_byteenable,
  output var  pgd_pkg::pgd_data_t o_avs_readdata,
  output var  logic               o_avs_waitrequest,
  // port pins
  input  wire pgd_pkg::pgd_port_t i_pin_in,
  output var  pgd_pkg::pgd_port_t o_pin_out,
  output var  pgd_pkg::pgd_port_t o_pin_oe,
  output var  pgd_pkg::pgd_port_t o_pin_slew,
  output var  pgd_pkg::pgd_port_t o_pin_drive
);
  import pgd_pkg::*;

  pgd_state_t q;
  pgd_state_t next_q;

  logic      req;
  logic      accept;
  logic      wr_acc;
  logic      gang_hit;
  pgd_port_t gang_mask;
  pgd_port_t eff_out;
  pgd_port_t eff_oe;
  pgd_port_t eff_slew;
  pgd_port_t eff_drive;
  pgd_port_t rd_value;

  // a request is answered one cycle after it is seen, so every access takes two
  assign req      = i_avs_read | i_avs_write;
  assign accept   = req & ~q.bus_wait;
  assign wr_acc   = accept & i_avs_write & i_avs_byteenable[0];
  assign gang_hit = i_avs_address == `PGD_OFS_GANG_CONTROL;

  // pins that take the master's settings, only while the gang is enabled
  assign gang_mask = {q.gang_ctrl[`PGD_GANG_SEL_MSB:`PGD_GANG_SEL_LSB], 1'b0}
                   & {`PGD_PORT_W{q.gang_ctrl[`PGD_GANG_ENABLE_BIT]}};

  // one pad cell per pin; pin 0 is the master and ignores the gang mask
  genvar n;
  generate
    for (n = 0; n < `PGD_PORT_W; n++) begin : g_pin
      pgd_pin_cell #(
        .IS_MASTER (n == `PGD_MASTER_PIN)
      ) u_cell (
        .i_use_master (gang_mask[n]),
        .i_force_oe   ((n == `PGD_MASTER_PIN) ? q.gang_ctrl[`PGD_GANG_ENABLE_BIT]
                                              : gang_mask[n]),
        .i_own_out    (q.out_latch[n]),
        .i_own_dir    (q.direction[n]),
        .i_own_slew   (q.slew_ctrl[n]),
        .i_own_drive  (q.drive_sel[n]),
        .i_mst_out    (q.out_latch[`PGD_MASTER_PIN]),
        .i_mst_slew   (q.slew_ctrl[`PGD_MASTER_PIN]),
        .i_mst_drive  (q.drive_sel[`PGD_MASTER_PIN]),
        .o_out        (eff_out[n]),
        .o_oe         (eff_oe[n]),
        .o_slew       (eff_slew[n]),
        .o_drive      (eff_drive[n])
      );
    end
  endgenerate

  // read mux; unmapped offsets read as zero
  always_comb begin
    case (i_avs_address)
      `PGD_OFS_OUTPUT_LATCH: rd_value = (eff_oe & q.out_latch) | (~eff_oe & q.pin_sync);
      `PGD_OFS_DIRECTION:    rd_value = q.direction;
      `PGD_OFS_SLEW_CTRL:    rd_value = q.slew_ctrl;
      `PGD_OFS_DRIVE_SEL:    rd_value = q.drive_sel;
      `PGD_OFS_GANG_CONTROL: rd_value = q.gang_ctrl;
      default:               rd_value = 8'h00;
    endcase
  end

  // next-state logic for bus, registers, synchroniser and pad outputs
  always_comb begin
    next_q = q;
    // waitrequest drops for exactly one cycle per request
    next_q.bus_wait = ~(req & q.bus_wait);
    if (req && q.bus_wait && i_avs_read) begin
      next_q.rdata = rd_value;
    end
    // writes land at the edge where waitrequest is sampled low
    if (wr_acc) begin
      case (i_avs_address)
        `PGD_OFS_OUTPUT_LATCH: next_q.out_latch = i_avs_writedata[7:0];
        `PGD_OFS_DIRECTION:    next_q.direction = i_avs_writedata[7:0];
        `PGD_OFS_SLEW_CTRL:    next_q.slew_ctrl = i_avs_writedata[7:0];
        `PGD_OFS_DRIVE_SEL:    next_q.drive_sel = i_avs_writedata[7:0];
        `PGD_OFS_GANG_CONTROL: begin
          // only the first write sticks; later ones are dropped silently
          if (!q.gang_locked) begin
            next_q.gang_ctrl   = i_avs_writedata[7:0];
            next_q.gang_locked = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // first stage is read only by the second
    next_q.pin_meta  = i_pin_in;
    next_q.pin_sync  = q.pin_meta;
    // pad controls leave through flops, one cycle behind the registers
    next_q.pin_out   = eff_out;
    next_q.pin_oe    = eff_oe;
    next_q.pin_slew  = eff_slew;
    next_q.pin_drive = eff_drive;
  end

  // state register; reset also re-arms the gang write-once lock
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q             <= '0;
      q.bus_wait    <= 1'b1;
      q.out_latch   <= `PGD_RST_OUTPUT_LATCH;
      q.direction   <= `PGD_RST_DIRECTION;
      q.slew_ctrl   <= `PGD_RST_SLEW_CTRL;
      q.drive_sel   <= `PGD_RST_DRIVE_SEL;
      q.gang_ctrl   <= `PGD_RST_GANG_CONTROL;
      q.gang_locked <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flops
  assign o_avs_readdata    = {24'h00_0000, q.rdata};
  assign o_avs_waitrequest = q.bus_wait;
  assign o_pin_out         = q.pin_out;
  assign o_pin_oe          = q.pin_oe;
  assign o_pin_slew        = q.pin_slew;
  assign o_pin_drive       = q.pin_drive;

  // checks on the block's own behaviour
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  slew_input_gate_a: assert property (
    (q.slew_ctrl != 8'h00) |=> ((o_pin_slew & ~o_pin_oe) == 8'h00))
    else $error("slew request shown on an input pin");

  drive_input_gate_a: assert property (
    ##1 ((o_pin_drive & ~o_pin_oe) == 8'h00) && (o_pin_drive == ($past(q.drive_sel) & o_pin_oe)
        || $past(gang_mask) != 8'h00))
    else $error("drive strength not following its bit for a driven pin");

  gang_write_once_a: assert property (
    (wr_acc && gang_hit && q.gang_locked) |=> $stable(q.gang_ctrl))
    else $error("gang control changed after the first write");

  gang_first_write_a: assert property (
    (wr_acc && gang_hit && !q.gang_locked)
      |=> (q.gang_ctrl == $past(i_avs_writedata[7:0])) && q.gang_locked)
    else $error("first gang control write not taken");

  gang_copy_master_a: assert property (
    (gang_mask != 8'h00) |=> ((o_pin_out & $past(gang_mask))
      == ({8{$past(q.out_latch[0])}} & $past(gang_mask)))
      && ((o_pin_slew & $past(gang_mask)) == ({8{$past(q.slew_ctrl[0])}} & $past(gang_mask))))
    else $error("ganged pin not copying the master pin");

  gang_idle_normal_a: assert property (
    !q.gang_ctrl[0] |=> (o_pin_out == $past(q.out_latch)) && (o_pin_oe == $past(q.direction)))
    else $error("pin not behaving individually while gang is off");

  master_forced_out_a: assert property (
    q.gang_ctrl[0] |=> o_pin_oe[0])
    else $error("master pin not driving while gang is on");

  data_read_mux_a: assert property (
    (i_avs_read && q.bus_wait && i_avs_address == `PGD_OFS_OUTPUT_LATCH && q.gang_ctrl[0] == 1'b0)
      |=> !o_avs_waitrequest
          && o_avs_readdata[7:0] == (($past(q.direction) & $past(q.out_latch))
                                   | (~$past(q.direction) & $past(q.pin_sync))))
    else $error("data read returned the wrong source");

  reset_clear_a: assert property (@(posedge i_ref_clk)
    !$past(i_resetn) |-> (q.slew_ctrl == 8'h00) && (q.drive_sel == 8'h00)
                         && (q.gang_ctrl == 8'h00) && !q.gang_locked)
    else $error("settings not cleared by reset");

  bus_answer_a: assert property (
    (req && q.bus_wait) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");

  gang_enabled_c: cover property (wr_acc && gang_hit && i_avs_writedata[0] && !q.gang_locked);
  gang_ignored_c: cover property (wr_acc && gang_hit && q.gang_locked);
  ganged_drive_c: cover property (gang_mask[7] && q.out_latch[0]);
  pin_read_c:     cover property (accept && i_avs_read && (eff_oe != 8'hFF));

endmodule : pgd_top

`default_nettype wire

// file: tb/pgd_top_tb_top.sv
`default_nettype none
`include "pgd_map.svh"

module pgd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pgd_pkg::*;

  logic      i_ref_clk;
  logic      i_resetn;
  pgd_addr_t address;
  logic      read;
  logic      write;
  pgd_data_t wdata;
  logic [3:0] be;
  pgd_data_t rdata;
  logic      wait_req;
  pgd_port_t pin_in;
  pgd_port_t pin_out;
  pgd_port_t pin_oe;
  pgd_port_t pin_slew;
  pgd_port_t pin_drive;
  int        miscompares;
  int        tests_run;

  pgd_top i_dut (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_avs_address(address), .i_avs_read(read),
    .i_avs_write(write), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_pin_slew(pin_slew), .o_pin_drive(pin_drive)
  );

  // 100 MHz reference clock
  always #5 i_ref_clk = ~i_ref_clk;

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one avalon access: raised just after a rising edge, held until waitrequest is
  // sampled low at a rising edge; read data is taken and the request dropped there
  task automatic bus(input logic rd, input pgd_addr_t a, input logic [7:0] d, input logic [3:0] b,
                     output pgd_data_t q);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    address <= a;
    read    <= rd;
    write   <= !rd;
    wdata   <= {24'h00_0000, d};
    be      <= b;
    @(posedge i_ref_clk);
    while (wait_req !== 1'b0 && n < 20) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (wait_req !== 1'b0) begin
      miscompares++;
      end_sim();
    end
    q = rdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input pgd_addr_t a, input logic [7:0] d);
    pgd_data_t q;
    bus(1'b0, a, d, 4'h1, q);
  endtask : wr

  task automatic rd(input string name, input pgd_addr_t a, input logic [7:0] exp);
    pgd_data_t q;
    bus(1'b1, a, 8'h00, 4'h1, q);
    chk(name, q, {24'h00_0000, exp});
  endtask : rd

  // pads settle one cycle after the register; non-driving pins are not judged on level
  task automatic pins(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] slw,
                      input logic [7:0] drv);
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk("pin_oe", {24'h00_0000, pin_oe}, {24'h00_0000, oe});
    chk("pin_out", {24'h00_0000, pin_out & oe}, {24'h00_0000, out});
    chk("pin_slew", {24'h00_0000, pin_slew}, {24'h00_0000, slw});
    chk("pin_drive", {24'h00_0000, pin_drive}, {24'h00_0000, drv});
  endtask : pins

  task automatic do_reset(input int cycles);
    @(posedge i_ref_clk);
    i_resetn <= 1'b0;
    repeat (cycles) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
  endtask : do_reset

  // every register cleared, unmapped word reads zero
  task automatic t_reset;
    rd("latch", `PGD_OFS_OUTPUT_LATCH, 8'h00);
    rd("direction", `PGD_OFS_DIRECTION, 8'h00);
    rd("slew", `PGD_OFS_SLEW_CTRL, 8'h00);
    rd("drive", `PGD_OFS_DRIVE_SEL, 8'h00);
    rd("gang", `PGD_OFS_GANG_CONTROL, 8'h00);
    rd("unmapped", 5'h14, 8'h00);
    pins(8'h00, 8'h00, 8'h00, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // slew and drive only reach driving pins; reads mix latch and pin level
  task automatic t_pad;
    pgd_data_t q;
    @(posedge i_ref_clk);
    pin_in <= 8'h3C;
    wr(`PGD_OFS_DIRECTION, 8'hF0);
    wr(`PGD_OFS_OUTPUT_LATCH, 8'hA5);
    wr(`PGD_OFS_SLEW_CTRL, 8'hFF);
    wr(`PGD_OFS_DRIVE_SEL, 8'h0F);
    pins(8'hF0, 8'hA0, 8'hF0, 8'h00);
    wr(`PGD_OFS_DRIVE_SEL, 8'hF0);
    pins(8'hF0, 8'hA0, 8'hF0, 8'hF0);
    rd("slew_rb", `PGD_OFS_SLEW_CTRL, 8'hFF);
    rd("drive_rb", `PGD_OFS_DRIVE_SEL, 8'hF0);
    rd("dir_rb", `PGD_OFS_DIRECTION, 8'hF0);
    rd("latch_mix", `PGD_OFS_OUTPUT_LATCH, 8'hAC);
    bus(1'b0, `PGD_OFS_OUTPUT_LATCH, 8'h00, 4'h0, q);
    rd("latch_be0", `PGD_OFS_OUTPUT_LATCH, 8'hAC);
    $display("test pad done");
  endtask : t_pad

  // selects without the enable leave pins alone, and the register locks
  task automatic t_gang_off;
    wr(`PGD_OFS_GANG_CONTROL, 8'h06);
    rd("gang_first", `PGD_OFS_GANG_CONTROL, 8'h06);
    pins(8'hF0, 8'hA0, 8'hF0, 8'hF0);
    wr(`PGD_OFS_GANG_CONTROL, 8'h07);
    rd("gang_locked", `PGD_OFS_GANG_CONTROL, 8'h06);
    pins(8'hF0, 8'hA0, 8'hF0, 8'hF0);
    $display("test gang_off done");
  endtask : t_gang_off

  // after a reset the lock is re-armed; pins 1 and 2 copy master pin 0
  task automatic t_gang_on;
    pin_in <= 8'h00;
    rd("gang_rearm", `PGD_OFS_GANG_CONTROL, 8'h00);
    wr(`PGD_OFS_OUTPUT_LATCH, 8'h01);
    wr(`PGD_OFS_SLEW_CTRL, 8'h01);
    wr(`PGD_OFS_DRIVE_SEL, 8'h01);
    wr(`PGD_OFS_GANG_CONTROL, 8'h07);
    pins(8'h07, 8'h07, 8'h07, 8'h07);
    rd("gang_latch", `PGD_OFS_OUTPUT_LATCH, 8'h01);
    pin_in <= 8'hFF;
    repeat (3) @(posedge i_ref_clk);
    rd("gang_pinmix", `PGD_OFS_OUTPUT_LATCH, 8'hF9);
    wr(`PGD_OFS_GANG_CONTROL, 8'h00);
    rd("gang_once", `PGD_OFS_GANG_CONTROL, 8'h07);
    wr(`PGD_OFS_OUTPUT_LATCH, 8'h00);
    wr(`PGD_OFS_SLEW_CTRL, 8'h00);
    pins(8'h07, 8'h00, 8'h00, 8'h07);
    $display("test gang_on done");
  endtask : t_gang_on

  initial begin
    i_ref_clk   = 1'b0;
    i_resetn    = 1'b0;
    address     = 5'h00;
    read        = 1'b0;
    write       = 1'b0;
    wdata       = 32'h0000_0000;
    be          = 4'h0;
    pin_in      = 8'h00;
    miscompares = 0;
    tests_run   = 0;
    repeat (20) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_pad();
    t_gang_off();
    do_reset(3);
    t_gang_on();
    end_sim();
  end

endmodule : pgd_top_tb_top

`default_nettype wire
